/* core/phy_ctrl_pkg.sv */
// Purpose: Shared constants and types for the basic control register
// Assumes: APB slave, 32-bit data, pclk at 250 MHz
// Notes:   Field layout of the 16-bit control word is the ctrl_t struct
// What this block does
// - Writing one to bit 15 starts a transceiver reset at once; the bit clears itself when the reset ends.
// - With bit 14 set, transmit data is looped back to receive data and the line link is dropped; both resets clear it.
// - Speed is decoded from bit 6 (high) and bit 13 (low): 00 is 10 Mbit/s, 01 is 100 Mbit/s, 10 and 11 reserved.
// - Hardware reset loads the speed pair as 0 and the speed strap without auto-negotiation, 01 with it; software reset keeps it.
// - Bit 12 loads from the auto-negotiation strap on hardware reset and survives software reset.
// - Bit 11 powers the device down; clearing it performs a software reset and a restart of auto-negotiation.
// - Bit 10 tristates all interface outputs and ignores all interface inputs; it resets to zero.
// - Writing one to bit 9 restarts auto-negotiation and the bit then clears itself.
// - Every hardware and software reset restarts auto-negotiation whatever bit 9 holds.
// - Hardware reset loads bit 8 as zero without auto-negotiation, else from the duplex strap; one is full duplex.
// - With bit 7 set, the collision output follows transmit enable; both resets clear it.
// - Bits 5 to 0 read zero and ignore writes.
package phy_ctrl_pkg;

  // ****************************************
  // Bus map
  // ****************************************
  localparam int          ADDR_W     = 12;
  localparam int          DATA_W     = 32;
  localparam logic [11:0] CTRL_OFFS  = 12'h000;
  localparam logic [11:0] STATE_OFFS = 12'h004;

  // ****************************************
  // Control word layout
  // ****************************************
  typedef struct packed {
    logic       sw_reset;
    logic       loopback;
    logic       speed_lsb;
    logic       an_enable;
    logic       power_down;
    logic       isolate;
    logic       an_restart;
    logic       full_duplex;
    logic       col_test;
    logic       speed_msb;
    logic [5:0] reserved;
  } ctrl_t;

  localparam logic [15:0] CTRL_RESET = 16'h0000;

  typedef enum logic [1:0] {
    SPEED_10   = 2'b00,
    SPEED_100  = 2'b01,
    SPEED_RSV2 = 2'b10,
    SPEED_RSV3 = 2'b11
  } speed_t;

  // ****************************************
  // State word bit positions
  // ****************************************
  localparam int ST_RESET_BUSY  = 0;
  localparam int ST_POWER_DOWN  = 1;
  localparam int ST_LINK_ENABLE = 2;
  localparam int ST_SPEED_RSV   = 3;
  localparam int ST_FULL_DUPLEX = 4;
  localparam int ST_SPEED_100   = 5;
  localparam int ST_STRAP_AN    = 6;
  localparam int ST_STRAP_SPEED = 7;
  localparam int ST_STRAP_DUP   = 8;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_PERIOD_NS   = 4;
  localparam int SW_RESET_NS     = 40;
  localparam int SW_RESET_CYCLES =
    (SW_RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SYNC_STAGES     = 2;

  // ****************************************
  // Interface carriers
  // ****************************************
  typedef struct packed {
    logic [3:0] txd;
    logic       tx_en;
  } mii_tx_t;

  typedef struct packed {
    logic [3:0] rxd;
    logic       rx_dv;
  } mii_rx_t;

  typedef enum logic [1:0] {
    INIT_SETTLE,
    INIT_LOAD,
    INIT_RUN
  } init_st_t;

endpackage

/* core/sw_reset_timer.sv */
// Purpose: Times the software reset of the transceiver
// Assumes: start is a one-cycle pulse on pclk
// Notes:   A start while busy reloads the count
`timescale 1ns/100ps
`default_nettype none
module sw_reset_timer #(
  parameter int CYCLES = phy_ctrl_pkg::SW_RESET_CYCLES
) (
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // Control
  input  wire logic start,
  output var  logic busy,
  output var  logic done
);

  localparam int CNT_W = $clog2(CYCLES + 1);

  initial begin
    if (CYCLES < 1) begin
      $error("sw_reset_timer: CYCLES must be at least 1");
    end
  end

  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  logic             done_d;

  assign done_d = (cnt_q == CNT_W'(1)) && !start;

  always_comb begin
    cnt_d = cnt_q;
    if (start) begin
      cnt_d = CNT_W'(CYCLES);
    end else if (cnt_q != '0) begin
      cnt_d = cnt_q - CNT_W'(1);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= '0;
      busy  <= 1'b0;
      done  <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      busy  <= (cnt_d != '0);
      done  <= done_d;
    end
  end

endmodule // sw_reset_timer
`default_nettype wire

/* core/phy_basic_control_register.sv */
// Purpose: Basic control register and its data-path side effects
// Assumes: MII and strap pins are asynchronous to pclk
// Notes:   APB slave with one wait state on every access once the straps are loaded
//
// Our own choices: the address map and register access over APB.
`timescale 1ns/100ps
`default_nettype none
module phy_basic_control_register #(
  parameter int RESET_CYCLES = phy_ctrl_pkg::SW_RESET_CYCLES
) (
  // Clock and reset
  input  wire logic                             pclk,
  input  wire logic                             presetn,
  // APB slave
  input  wire logic                             psel,
  input  wire logic                             penable,
  input  wire logic                             pwrite,
  input  wire logic [phy_ctrl_pkg::ADDR_W-1:0]  paddr,
  input  wire logic [phy_ctrl_pkg::DATA_W-1:0]  pwdata,
  input  wire logic [3:0]                       pstrb,
  output var  logic [phy_ctrl_pkg::DATA_W-1:0]  prdata,
  output var  logic                             pready,
  output var  logic                             pslverr,
  // Strap pins
  input  wire logic                             anen_strap,
  input  wire logic                             speed_strap,
  input  wire logic                             duplex_strap,
  // MAC side interface
  input  wire phy_ctrl_pkg::mii_tx_t            mac_tx,
  output var  phy_ctrl_pkg::mii_rx_t            mac_rx,
  output var  logic                             mac_rx_oe,
  output var  logic                             col,
  output var  logic                             col_oe,
  // Line side data path
  output var  phy_ctrl_pkg::mii_tx_t            line_tx,
  input  wire phy_ctrl_pkg::mii_rx_t            line_rx,
  // Transceiver control
  output var  logic                             core_reset,
  output var  logic                             an_restart,
  output var  logic                             power_down,
  output var  logic                             link_enable,
  output var  logic                             speed_100,
  output var  logic                             full_duplex
);

  initial begin
    if (RESET_CYCLES < 1) begin
      $error("phy_basic_control_register: RESET_CYCLES below 1");
    end
  end

  // ****************************************
  // Functions
  // ****************************************
  function automatic logic [31:0] ctrl_word(
    input phy_ctrl_pkg::ctrl_t c
  );
    phy_ctrl_pkg::ctrl_t r;
    r          = c;
    r.reserved = '0;
    return {16'h0000, 16'(r)};
  endfunction

  function automatic phy_ctrl_pkg::speed_t speed_of(
    input phy_ctrl_pkg::ctrl_t c
  );
    return phy_ctrl_pkg::speed_t'({c.speed_msb, c.speed_lsb});
  endfunction

  // ****************************************
  // Synchronisers
  // ****************************************
  logic [2:0]            strap_s1_q;
  logic [2:0]            strap_s2_q;
  phy_ctrl_pkg::mii_tx_t tx_s1_q;
  phy_ctrl_pkg::mii_tx_t tx_s2_q;
  phy_ctrl_pkg::mii_rx_t rx_s1_q;
  phy_ctrl_pkg::mii_rx_t rx_s2_q;

  // Straps are caught only after release, never by the reset itself
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strap_s1_q <= '0;
      strap_s2_q <= '0;
      tx_s1_q    <= '0;
      tx_s2_q    <= '0;
      rx_s1_q    <= '0;
      rx_s2_q    <= '0;
    end else begin
      strap_s1_q <= {anen_strap, speed_strap, duplex_strap};
      strap_s2_q <= strap_s1_q;
      tx_s1_q    <= mac_tx;
      tx_s2_q    <= tx_s1_q;
      rx_s1_q    <= line_rx;
      rx_s2_q    <= rx_s1_q;
    end
  end

  // ****************************************
  // Hardware reset sequence
  // ****************************************
  localparam int SET_W = $clog2(phy_ctrl_pkg::SYNC_STAGES + 1);

  phy_ctrl_pkg::init_st_t init_q;
  phy_ctrl_pkg::init_st_t init_d;
  logic [SET_W-1:0]       settle_q;
  logic [SET_W-1:0]       settle_d;
  logic [2:0]             strap_q;
  logic [2:0]             strap_d;
  wire                    in_load = (init_q == phy_ctrl_pkg::INIT_LOAD);
  wire                    in_run  = (init_q == phy_ctrl_pkg::INIT_RUN);

  always_comb begin
    init_d   = init_q;
    settle_d = settle_q;
    strap_d  = strap_q;
    case (init_q)
      phy_ctrl_pkg::INIT_SETTLE: begin
        settle_d = settle_q + SET_W'(1);
        if (settle_q == SET_W'(phy_ctrl_pkg::SYNC_STAGES - 1)) begin
          init_d = phy_ctrl_pkg::INIT_LOAD;
        end
      end
      phy_ctrl_pkg::INIT_LOAD: begin
        strap_d = strap_s2_q;
        init_d  = phy_ctrl_pkg::INIT_RUN;
      end
      default: begin
        init_d = phy_ctrl_pkg::INIT_RUN;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      init_q   <= phy_ctrl_pkg::INIT_SETTLE;
      settle_q <= '0;
      strap_q  <= '0;
    end else begin
      init_q   <= init_d;
      settle_q <= settle_d;
      strap_q  <= strap_d;
    end
  end

  // ****************************************
  // APB decode
  // ****************************************
  phy_ctrl_pkg::ctrl_t ctrl_q;
  phy_ctrl_pkg::ctrl_t ctrl_d;
  logic                pready_q;
  logic [31:0]         prdata_q;
  logic [31:0]         prdata_d;
  logic                pslverr_q;
  logic [31:0]         state_word;
  logic                rst_busy;
  logic                rst_done;

  wire hit_ctrl  = (paddr == phy_ctrl_pkg::CTRL_OFFS);
  wire hit_state = (paddr == phy_ctrl_pkg::STATE_OFFS);
  wire unmapped  = !hit_ctrl && !hit_state;
  // Answer only once straps are in, so reads never see the blank word
  wire pready_d  = psel && penable && !pready_q && in_run;
  wire commit    = psel && penable && pready_q;
  wire wr_ctrl   = commit && pwrite && hit_ctrl;
  wire wr_hi     = wr_ctrl && pstrb[1];
  wire wr_lo     = wr_ctrl && pstrb[0];

  phy_ctrl_pkg::ctrl_t wr_c;
  assign wr_c = phy_ctrl_pkg::ctrl_t'(pwdata[15:0]);

  always_comb begin
    prdata_d = 32'h0000_0000;
    if (!pwrite && hit_ctrl) begin
      prdata_d = ctrl_word(ctrl_q);
    end else if (!pwrite && hit_state) begin
      prdata_d = state_word;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      prdata_q  <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else begin
      pready_q  <= pready_d;
      prdata_q  <= pready_d ? prdata_d : 32'h0000_0000;
      pslverr_q <= pready_d && unmapped;
    end
  end

  // ****************************************
  // Control register
  // ****************************************
  wire pd_exit  = wr_hi && ctrl_q.power_down && !wr_c.power_down;
  wire rst_go   = (wr_hi && wr_c.sw_reset) || pd_exit;
  wire an_go    = wr_hi && wr_c.an_restart;
  wire strap_an = strap_s2_q[2];
  wire strap_sp = strap_s2_q[1];
  wire strap_dp = strap_s2_q[0];

  always_comb begin
    ctrl_d = ctrl_q;
    if (in_load) begin
      ctrl_d.an_enable   = strap_an;
      ctrl_d.speed_msb   = 1'b0;
      ctrl_d.speed_lsb   = strap_an || strap_sp;
      ctrl_d.full_duplex = strap_an && strap_dp;
    end
    if (rst_done) begin
      ctrl_d.loopback   = 1'b0;
      ctrl_d.power_down = 1'b0;
      ctrl_d.isolate    = 1'b0;
      ctrl_d.col_test   = 1'b0;
    end
    // Restart was issued the same edge it was set
    ctrl_d.an_restart = 1'b0;
    if (wr_hi) begin
      ctrl_d.loopback    = wr_c.loopback;
      ctrl_d.speed_lsb   = wr_c.speed_lsb;
      ctrl_d.an_enable   = wr_c.an_enable;
      ctrl_d.power_down  = wr_c.power_down;
      ctrl_d.isolate     = wr_c.isolate;
      ctrl_d.full_duplex = wr_c.full_duplex;
    end
    if (an_go) begin
      ctrl_d.an_restart = 1'b1;
    end
    if (wr_lo) begin
      ctrl_d.col_test  = wr_c.col_test;
      ctrl_d.speed_msb = wr_c.speed_msb;
    end
    // Set wins over the end of a running reset
    if (rst_go) begin
      ctrl_d.sw_reset = 1'b1;
    end else if (rst_done) begin
      ctrl_d.sw_reset = 1'b0;
    end
    ctrl_d.reserved = '0;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= phy_ctrl_pkg::ctrl_t'(phy_ctrl_pkg::CTRL_RESET);
    end else begin
      ctrl_q <= ctrl_d;
    end
  end

  sw_reset_timer #(
    .CYCLES (RESET_CYCLES)
  ) u_reset_timer (
    .pclk    (pclk),
    .presetn (presetn),
    .start   (rst_go),
    .busy    (rst_busy),
    .done    (rst_done)
  );

  // ****************************************
  // Side effects
  // ****************************************
  phy_ctrl_pkg::speed_t speed_sel;
  assign speed_sel = speed_of(ctrl_q);

  wire quiet      = ctrl_q.isolate || ctrl_q.power_down;
  wire core_rst_d = rst_go || rst_busy || !in_run;
  wire an_rst_d   = in_load || rst_done || an_go;
  wire spd100_d   = (speed_sel == phy_ctrl_pkg::SPEED_100);
  wire spd_rsv    = (speed_sel == phy_ctrl_pkg::SPEED_RSV2) ||
                    (speed_sel == phy_ctrl_pkg::SPEED_RSV3);

  phy_ctrl_pkg::mii_tx_t tx_eff;
  phy_ctrl_pkg::mii_tx_t line_tx_d;
  phy_ctrl_pkg::mii_rx_t mac_rx_d;
  logic                  link_d;
  logic                  col_d;

  // Isolated or powered down: MAC inputs are ignored
  assign tx_eff = quiet ? '0 : tx_s2_q;

  assign line_tx_d = (ctrl_q.loopback || core_rst_d) ? '0 : tx_eff;

  assign mac_rx_d =
    core_rst_d      ? '0 :
    ctrl_q.loopback ? phy_ctrl_pkg::mii_rx_t'({tx_eff.txd, tx_eff.tx_en}) :
    quiet           ? '0 : rx_s2_q;

  // Loopback breaks the line link
  assign link_d = !ctrl_q.loopback && !quiet && !core_rst_d;

  assign col_d = tx_eff.tx_en &&
                 (ctrl_q.col_test ||
                  (!ctrl_q.full_duplex && !ctrl_q.loopback &&
                   rx_s2_q.rx_dv));

  assign state_word = {
    23'h00_0000,
    strap_q[0],
    strap_q[1],
    strap_q[2],
    spd100_d,
    ctrl_q.full_duplex,
    spd_rsv,
    link_enable,
    ctrl_q.power_down,
    ctrl_q.sw_reset
  };

  logic mac_rx_oe_q;
  logic col_q;
  logic col_oe_q;
  logic core_reset_q;
  logic an_restart_q;
  logic power_down_q;
  logic link_enable_q;
  logic speed_100_q;
  logic full_duplex_q;
  phy_ctrl_pkg::mii_rx_t mac_rx_q;
  phy_ctrl_pkg::mii_tx_t line_tx_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mac_rx_q      <= '0;
      mac_rx_oe_q   <= 1'b0;
      col_q         <= 1'b0;
      col_oe_q      <= 1'b0;
      line_tx_q     <= '0;
      core_reset_q  <= 1'b1;
      an_restart_q  <= 1'b0;
      power_down_q  <= 1'b0;
      link_enable_q <= 1'b0;
      speed_100_q   <= 1'b0;
      full_duplex_q <= 1'b0;
    end else begin
      mac_rx_q      <= mac_rx_d;
      mac_rx_oe_q   <= !ctrl_q.isolate;
      col_q         <= col_d;
      col_oe_q      <= !ctrl_q.isolate;
      line_tx_q     <= line_tx_d;
      core_reset_q  <= core_rst_d;
      an_restart_q  <= an_rst_d;
      power_down_q  <= ctrl_q.power_down;
      link_enable_q <= link_d;
      speed_100_q   <= spd100_d;
      full_duplex_q <= ctrl_q.full_duplex;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign prdata      = prdata_q;
  assign pready      = pready_q;
  assign pslverr     = pslverr_q;
  assign mac_rx      = mac_rx_q;
  assign mac_rx_oe   = mac_rx_oe_q;
  assign col         = col_q;
  assign col_oe      = col_oe_q;
  assign line_tx     = line_tx_q;
  assign core_reset  = core_reset_q;
  assign an_restart  = an_restart_q;
  assign power_down  = power_down_q;
  assign link_enable = link_enable_q;
  assign speed_100   = speed_100_q;
  assign full_duplex = full_duplex_q;

endmodule // phy_basic_control_register
`default_nettype wire

/* test/phy_ctrl_props.sv */
// Purpose: Port level checks of the control register block
// Assumes: APB slave with one wait state, as handed over
// Notes:   Bound to the top module at the foot of this file
`timescale 1ns/100ps
`default_nettype none
module phy_ctrl_props #(
  parameter int RESET_CYCLES = 10
) (
  // Clock and reset
  input wire logic                        pclk,
  input wire logic                        presetn,
  // APB
  input wire logic                        psel,
  input wire logic                        penable,
  input wire logic                        pwrite,
  input wire logic [11:0]                 paddr,
  input wire logic [31:0]                 pwdata,
  input wire logic [3:0]                  pstrb,
  input wire logic [31:0]                 prdata,
  input wire logic                        pready,
  input wire logic                        pslverr,
  // Data path and control
  input wire phy_ctrl_pkg::mii_rx_t       mac_rx,
  input wire logic                        mac_rx_oe,
  input wire logic                        col_oe,
  input wire phy_ctrl_pkg::mii_tx_t       line_tx,
  input wire logic                        core_reset,
  input wire logic                        an_restart
);
  // Slack for the reset bound, rewrites while busy excluded
  localparam int RST_MAX = 4 * RESET_CYCLES + 8;
  wire wr_ctrl = psel & penable & pready & pwrite & pstrb[1] &
                 (paddr == phy_ctrl_pkg::CTRL_OFFS);
  wire rd_ctrl = pready & ~pwrite & (paddr == phy_ctrl_pkg::CTRL_OFFS);

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // ****
  // Bus, field, reset and output checks
  // ****
  chk_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  chk_err_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  chk_idle_data: assert property (!pready |-> prdata == 32'h0000_0000)
    else $error("read data outside answer");
  chk_rsv_zero: assert property (
    rd_ctrl |-> prdata[31:16] == 16'h0000 && prdata[5:0] == 6'h00)
    else $error("reserved bits not zero");
  chk_sw_reset_go: assert property (
    wr_ctrl && pwdata[15] |-> ##[1:2] core_reset)
    else $error("software reset did not start");
  chk_reset_end: assert property (
    $rose(core_reset) |-> core_reset[*4] ##[1:RST_MAX] !core_reset)
    else $error("software reset length wrong");
  chk_restart_sw: assert property (
    $rose(core_reset) |-> ##[1:RST_MAX] an_restart)
    else $error("no restart after software reset");
  chk_restart_hw: assert property (
    $rose(presetn) |-> ##[1:8] an_restart)
    else $error("no restart after hardware reset");
  chk_restart_bit: assert property (
    wr_ctrl && pwdata[9] |=> an_restart)
    else $error("restart bit had no effect");
  chk_oe_pair: assert property (col_oe == mac_rx_oe)
    else $error("output enables disagree");
  chk_reset_quiet: assert property (
    core_reset && $past(core_reset) |->
      line_tx == 5'h00 && mac_rx == 5'h00)
    else $error("data moves during reset");

  cover property (wr_ctrl && pwdata[15]);
  cover property (wr_ctrl && pwdata[9]);
  cover property (pslverr);
  cover property ($fell(mac_rx_oe));
endmodule // phy_ctrl_props

bind phy_basic_control_register phy_ctrl_props #(
  .RESET_CYCLES(RESET_CYCLES)
) i_phy_ctrl_props (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .pwdata, .pstrb, .prdata, .pready, .pslverr, .mac_rx, .mac_rx_oe,
  .col_oe, .line_tx, .core_reset, .an_restart);
`default_nettype wire

/* test/mac_line_model.sv */
// Purpose: MAC transmit side and idle line side of the block
// Assumes: Bench raises send to present one steady nibble
// Notes:   Idle nibbles toggle so stale data cannot pass as data
`timescale 1ns/100ps
`default_nettype none
module mac_line_model (
  // Clock
  input  wire logic                  pclk,
  // Bench control
  input  wire logic                  send,
  input  wire logic [3:0]            nib,
  // Pins toward the block
  output var  phy_ctrl_pkg::mii_tx_t mac_tx,
  output var  phy_ctrl_pkg::mii_rx_t line_rx
);
  logic [3:0] idle_q = 4'h5;
  always @(posedge pclk) begin
    idle_q <= ~idle_q;
  end
  assign mac_tx  = send ? {nib, 1'b1} : {idle_q, 1'b0};
  assign line_rx = {idle_q, 1'b0};
endmodule // mac_line_model
`default_nettype wire

/* test/phy_basic_control_register_bench.sv */
// Purpose: Self checking bench of the basic control register
// Assumes: One wait state APB slave, reset cycles set to 10
// Notes:   All waits are bounded and end in the verdict
`timescale 1ns/100ps
`default_nettype none
module phy_basic_control_register_bench;
  localparam logic [11:0] CTRL = phy_ctrl_pkg::CTRL_OFFS;
  logic        pclk = 1'b0, presetn = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
  logic [3:0]  pstrb = 4'hF;
  logic        pready, pslverr, err, send = 1'b0;
  logic        anen_strap = 1'b0, speed_strap = 1'b0, duplex_strap = 1'b0;
  logic [3:0]  nib = 4'h0;
  phy_ctrl_pkg::mii_tx_t mac_tx, line_tx;
  phy_ctrl_pkg::mii_rx_t mac_rx, line_rx;
  logic        mac_rx_oe, col, col_oe, core_reset, an_restart;
  logic        power_down, link_enable, speed_100, full_duplex;
  int          error_cnt = 0, n_checks = 0, restarts = 0, r0;

  phy_basic_control_register #(
    .RESET_CYCLES(10)
  ) i_phy_basic_control_register (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
    .prdata, .pready, .pslverr, .anen_strap, .speed_strap, .duplex_strap,
    .mac_tx, .mac_rx, .mac_rx_oe, .col, .col_oe, .line_tx, .line_rx,
    .core_reset, .an_restart, .power_down, .link_enable, .speed_100,
    .full_duplex);
  mac_line_model i_mac_line_model (.pclk, .send, .nib, .mac_tx, .line_rx);

  initial begin
    forever #2 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    if (an_restart === 1'b1) restarts <= restarts + 1;
  end

  // ****
  // Tasks
  // ****
  task automatic give_verdict();
    if (error_cnt == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic fail(input string m);
    error_cnt++;
    $display("Error at %0t: %s", $time, m);
  endtask
  task automatic cmp_word(input logic [31:0] got, exp, input string m);
    n_checks++;
    if (got !== exp) fail(m);
  endtask
  task automatic cmp_bit(input logic got, exp, input string m);
    n_checks++;
    if (got !== exp) fail(m);
  endtask
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 200);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 200) fail("bus timeout");
    if (n >= 200) give_verdict();
  endtask
  task automatic hw_reset(input logic an, sp, dp);
    presetn <= 1'b0;
    anen_strap <= an;
    speed_strap <= sp;
    duplex_strap <= dp;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
  endtask
  // Waits out init or a software reset, then the data path latency
  task automatic settle();
    int n;
    n = 0;
    repeat (2) @(posedge pclk);
    while (core_reset !== 1'b0 && n < 100) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 100) fail("reset never ended");
    if (n >= 100) give_verdict();
    repeat (3) @(posedge pclk);
  endtask

  // ****
  // Sequence
  // ****
  initial begin
    logic [31:0] d;
    hw_reset(1'b0, 1'b1, 1'b1);
    settle();
    apb(1'b0, CTRL, 32'h0000_0000);
    cmp_word(rd, 32'h0000_2000, "strap load");
    cmp_word(restarts, 32'h0000_0001, "init restart");
    apb(1'b1, CTRL, 32'h0000_203F);
    apb(1'b0, CTRL, 32'h0000_0000);
    cmp_word(rd, 32'h0000_2000, "reserved write");
    for (int k = 0; k < 4; k++) begin
      d = 32'h0000_0000;
      d[6] = k[1];
      d[13] = k[0];
      apb(1'b1, CTRL, d);
      repeat (3) @(posedge pclk);
      cmp_bit(speed_100, k == 1, "speed decode");
      apb(1'b0, CTRL, 32'h0000_0000);
      cmp_word(rd, d, "speed hold");
      apb(1'b0, phy_ctrl_pkg::STATE_OFFS, 32'h0000_0000);
      cmp_bit(rd[3], k >= 2, "speed reserved flag");
    end
    apb(1'b1, CTRL, 32'h0000_6580);
    apb(1'b0, CTRL, 32'h0000_0000);
    cmp_word(rd, 32'h0000_6580, "field hold");
    repeat (3) @(posedge pclk);
    cmp_bit(mac_rx_oe, 1'b0, "isolate rx");
    cmp_bit(col_oe, 1'b0, "isolate col");
    apb(1'b1, CTRL, 32'h0000_6180);
    send <= 1'b1;
    nib <= 4'hA;
    repeat (6) @(posedge pclk);
    cmp_word({27'h0, mac_rx}, {27'h0, 4'hA, 1'b1}, "loop data");
    cmp_word({27'h0, line_tx}, 32'h0000_0000, "loop line");
    cmp_bit(link_enable, 1'b0, "loop link");
    cmp_bit(col, 1'b1, "col test on");
    cmp_bit(mac_rx_oe, 1'b1, "rx driven");
    apb(1'b1, CTRL, 32'h0000_6100);
    repeat (4) @(posedge pclk);
    cmp_bit(col, 1'b0, "col test off");
    apb(1'b1, CTRL, 32'h0000_6180);
    r0 = restarts;
    apb(1'b1, CTRL, 32'h0000_E180);
    apb(1'b0, CTRL, 32'h0000_0000);
    cmp_word(rd, 32'h0000_E180, "reset pending");
    settle();
    apb(1'b0, CTRL, 32'h0000_0000);
    cmp_word(rd, 32'h0000_2100, "reset done");
    cmp_word(restarts - r0, 32'h0000_0001, "reset restart");
    cmp_word({27'h0, line_tx}, {27'h0, 4'hA, 1'b1}, "line data");
    cmp_bit(link_enable, 1'b1, "link back");
    send <= 1'b0;
    r0 = restarts;
    apb(1'b1, CTRL, 32'h0000_2300);
    apb(1'b0, CTRL, 32'h0000_0000);
    cmp_word(rd, 32'h0000_2100, "restart clears");
    cmp_word(restarts - r0, 32'h0000_0001, "restart pulse");
    apb(1'b1, CTRL, 32'h0000_2900);
    repeat (2) @(posedge pclk);
    cmp_bit(power_down, 1'b1, "power down");
    r0 = restarts;
    apb(1'b1, CTRL, 32'h0000_2100);
    repeat (3) @(posedge pclk);
    cmp_bit(core_reset, 1'b1, "wake reset");
    settle();
    cmp_word(restarts - r0, 32'h0000_0001, "wake restart");
    cmp_bit(power_down, 1'b0, "awake");
    apb(1'b0, 12'h010, 32'h0000_0000);
    cmp_bit(err, 1'b1, "unmapped error");
    cmp_word(rd, 32'h0000_0000, "unmapped data");
    hw_reset(1'b1, 1'b0, 1'b1);
    settle();
    apb(1'b0, CTRL, 32'h0000_0000);
    cmp_word(rd, 32'h0000_3100, "strap load an");
    cmp_bit(full_duplex, 1'b1, "duplex strap");
    apb(1'b1, CTRL, 32'h0000_B100);
    settle();
    apb(1'b0, CTRL, 32'h0000_0000);
    cmp_word(rd, 32'h0000_3100, "kept by reset");
    give_verdict();
  end
endmodule // phy_basic_control_register_bench
`default_nettype wire
